// file: src/scp_device.sv
// chopper blanking, overcurrent / overtemperature protection and telegram receiver
//
// Decided for this implementation: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
module scp_device
    import scp_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    scp_link_if.dev          link,
    input  wire logic        pwmOsc,
    input  wire logic        chipDisableInput,
    input  wire logic        blankSelectHi,
    input  wire logic        blankSelectLo,
    input  wire logic [1:0]  chopComp,
    input  wire logic [1:0]  lsComp,
    input  wire logic        hsComp,
    input  wire logic        overTemp,
    output logic      [1:0]  bridgeOn,
    output logic      [1:0]  coilSign,
    output logic      [7:0]  coilMag,
    output logic      [1:0]  coilDecay,
    output logic      [2:0]  errFlag,
    output logic             overTempFlag
);
    ////////////////////////////////////////////////////////////////////////////
    // input synchronisers: every pin passes two flops
    localparam int SW = 13;
    // select idles high: a zero reset value would show a false select edge after reset
    localparam logic [SW-1:0] SYNC_IDLE = 13'h0800;
    logic [SW-1:0] syncA_r;
    logic [SW-1:0] syncB_r;
    logic          sclkPrev_r;
    logic          csPrev_r;
    logic          oscPrev_r;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            syncA_r    <= SYNC_IDLE;
            syncB_r    <= SYNC_IDLE;
            sclkPrev_r <= 1'b0;
            csPrev_r   <= 1'b1;
            oscPrev_r  <= 1'b0;
        end else begin
            syncA_r    <= {link.sclk, link.csN, link.mosi, pwmOsc, chipDisableInput, blankSelectHi,
                           blankSelectLo, chopComp, lsComp, hsComp, overTemp};
            syncB_r    <= syncA_r;
            sclkPrev_r <= syncB_r[12];
            csPrev_r   <= syncB_r[11];
            oscPrev_r  <= syncB_r[9];
        end
    end

    wire       sclkS     = syncB_r[12];
    wire       csS       = syncB_r[11];
    wire       mosiS     = syncB_r[10];
    wire       oscS      = syncB_r[9];
    wire       disabled  = syncB_r[8];
    wire [1:0] strapS    = syncB_r[7:6];
    wire [1:0] chopS     = syncB_r[5:4];
    wire [1:0] lsS       = syncB_r[3:2];
    wire       hsS       = syncB_r[1];
    wire       otS       = syncB_r[0];
    wire       sclkRise  = sclkS & ~sclkPrev_r;
    wire       csRise    = csS & ~csPrev_r;
    // bridge A chops on the rising oscillator edge, bridge B on the falling one
    wire [1:0] cycStart  = {~oscS & oscPrev_r, oscS & ~oscPrev_r};
    wire       clearAll  = !rst_n || disabled;

    ////////////////////////////////////////////////////////////////////////////
    // strap capture after reset release; straps are pins, not registers
    // wait until the synchronisers hold real pin levels, not their reset value
    localparam logic [1:0] STRAP_AGE = 2'h2;
    logic       strapValid_r;
    logic [1:0] strapAge_r;
    logic [1:0] blankSel_r;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            strapValid_r <= 1'b0;
            strapAge_r   <= 2'h0;
            blankSel_r   <= 2'h0;
        end else if (!strapValid_r) begin
            if (strapAge_r == STRAP_AGE) begin
                strapValid_r <= 1'b1;
                blankSel_r   <= strapS;
            end else begin
                strapAge_r <= strapAge_r + 2'h1;
            end
        end
    end

    wire [BLANK_W-1:0] blankLoad = (blankSel_r == 2'h0) ? BLANK_CYC_0 :
                                   (blankSel_r == 2'h1) ? BLANK_CYC_1 :
                                   (blankSel_r == 2'h2) ? BLANK_CYC_2 : BLANK_CYC_3;

    ////////////////////////////////////////////////////////////////////////////
    // telegram receiver
    logic [TELEGRAM_BITS-1:0] rxShift_r;
    logic [3:0]               rxCnt_r;
    logic [COIL_BITS-1:0]     coilA_r;
    logic [COIL_BITS-1:0]     coilB_r;
    logic                     zeroTel_r;

    wire telDone = csRise && (rxCnt_r == RX_FULL);
    wire telZero = (rxShift_r[COIL_BITS+MAG_MSB:COIL_BITS+MAG_LSB] == MAG_ZERO) &&
                   (rxShift_r[MAG_MSB:MAG_LSB] == MAG_ZERO);

    always_ff @(posedge core_clk) begin
        if (clearAll) begin
            rxShift_r <= '0;
            rxCnt_r   <= 4'h0;
            coilA_r   <= '0;
            coilB_r   <= '0;
            zeroTel_r <= 1'b0;
        end else begin
            zeroTel_r <= telDone && telZero;
            if (csS) begin
                rxCnt_r <= 4'h0;
            end else if (sclkRise && rxCnt_r != RX_OVER) begin
                // a frame of more than twelve bits is dropped whole
                rxShift_r <= {rxShift_r[TELEGRAM_BITS-2:0], mosiS};
                rxCnt_r   <= rxCnt_r + 4'h1;
            end
            if (telDone) begin
                coilA_r <= rxShift_r[TELEGRAM_BITS-1:COIL_BITS];
                coilB_r <= rxShift_r[COIL_BITS-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // blanking, chopper and protection
    logic [BLANK_W-1:0] blankCnt_r [2];
    logic [1:0]         onPhase_r;
    logic [1:0]         bridgeOn_r;
    logic [1:0]         errCnt_r   [3];
    logic [5:0]         lockCnt_r  [3];
    logic [6:0]         quietCnt_r [3];
    logic [2:0]         errFlag_r;
    logic               otFlag_r;

    wire [1:0] blanking = {blankCnt_r[1] != '0, blankCnt_r[0] != '0};
    wire [2:0] ocEvent;
    assign ocEvent[0] = lsS[0] & ~blanking[0] & bridgeOn_r[0];
    assign ocEvent[1] = lsS[1] & ~blanking[1] & bridgeOn_r[1];
    assign ocEvent[2] = hsS & ~(|blanking) & (|bridgeOn_r);
    // the high-side counter runs on bridge A's cycle since the faulty bridge is unknown
    wire [2:0] tick   = {cycStart[0], cycStart};
    wire [1:0] chopEnd = chopS & ~blanking & bridgeOn_r;
    wire [1:0] magNz  = {coilB_r[MAG_MSB:MAG_LSB] != MAG_ZERO, coilA_r[MAG_MSB:MAG_LSB] != MAG_ZERO};
    wire       hsLock = lockCnt_r[2] != '0;
    wire [1:0] locked = {lockCnt_r[1] != '0 || hsLock, lockCnt_r[0] != '0 || hsLock};

    always_ff @(posedge core_clk) begin
        if (clearAll) begin
            for (int i = 0; i < 3; i++) begin
                errCnt_r[i]   <= 2'h0;
                lockCnt_r[i]  <= 6'h00;
                quietCnt_r[i] <= 7'h00;
            end
            errFlag_r <= 3'h0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (ocEvent[i]) begin
                    quietCnt_r[i] <= 7'h00;
                    if (errCnt_r[i] != ERR_LIMIT) begin
                        errCnt_r[i] <= errCnt_r[i] + 2'h1;
                    end
                    if (errCnt_r[i] + 2'h1 == ERR_LIMIT || errCnt_r[i] == ERR_LIMIT) begin
                        lockCnt_r[i] <= LOCK_CYCLES;
                        errFlag_r[i] <= 1'b1;
                    end
                end else begin
                    // a new event beats a clearing telegram in the same cycle
                    if (zeroTel_r) begin
                        errFlag_r[i] <= 1'b0;
                        lockCnt_r[i] <= 6'h00;
                    end else if (tick[i] && lockCnt_r[i] != '0) begin
                        lockCnt_r[i] <= lockCnt_r[i] - 6'h01;
                    end
                    if (tick[i]) begin
                        if (quietCnt_r[i] == QUIET_CYCLES) begin
                            errCnt_r[i]   <= 2'h0;
                            quietCnt_r[i] <= 7'h00;
                        end else begin
                            quietCnt_r[i] <= quietCnt_r[i] + 7'h01;
                        end
                    end
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (clearAll) begin
            blankCnt_r[0] <= '0;
            blankCnt_r[1] <= '0;
            onPhase_r     <= 2'h0;
            bridgeOn_r    <= 2'h0;
            otFlag_r      <= 1'b0;
        end else begin
            otFlag_r <= otS;
            for (int i = 0; i < 2; i++) begin
                if (cycStart[i]) begin
                    blankCnt_r[i] <= blankLoad;
                    onPhase_r[i]  <= 1'b1;
                end else begin
                    if (blanking[i]) begin
                        blankCnt_r[i] <= blankCnt_r[i] - 1'b1;
                    end
                    // off for the rest of the cycle once chopped or faulted
                    if (chopEnd[i] || ocEvent[i] || ocEvent[2]) begin
                        onPhase_r[i] <= 1'b0;
                    end
                end
                // the turn-on edge restarts blanking, so drive follows the cycle start
                bridgeOn_r[i] <= (cycStart[i] || (onPhase_r[i] && !chopEnd[i] && !ocEvent[i] && !ocEvent[2]))
                                 && !locked[i] && !otS && magNz[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs straight from flops
    assign bridgeOn     = bridgeOn_r;
    assign coilSign     = {coilB_r[SIGN_BIT], coilA_r[SIGN_BIT]};
    assign coilMag      = {coilB_r[MAG_MSB:MAG_LSB], coilA_r[MAG_MSB:MAG_LSB]};
    assign coilDecay    = {coilB_r[DECAY_BIT], coilA_r[DECAY_BIT]};
    assign errFlag      = errFlag_r;
    assign overTempFlag = otFlag_r;
endmodule
`default_nettype wire

// file: shared/scp_pkg.sv
// constants shared by the stepper chopper protection device and its host controller
package scp_pkg;
    // core clock
    localparam int CLK_PERIOD_NS = 8;

    // least blank times in ns, selected by {blankSelectHi, blankSelectLo}
    localparam int BLANK_NS_0 = 600;
    localparam int BLANK_NS_1 = 900;
    localparam int BLANK_NS_2 = 1200;
    localparam int BLANK_NS_3 = 1500;
    localparam int BLANK_W    = 8;

    // a least time rounds up to whole clock cycles
    function automatic logic [BLANK_W-1:0] scpMinCycles(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        if (c < 1) begin
            c = 1;
        end
        return BLANK_W'(c);
    endfunction

    localparam logic [BLANK_W-1:0] BLANK_CYC_0 = scpMinCycles(BLANK_NS_0);
    localparam logic [BLANK_W-1:0] BLANK_CYC_1 = scpMinCycles(BLANK_NS_1);
    localparam logic [BLANK_W-1:0] BLANK_CYC_2 = scpMinCycles(BLANK_NS_2);
    localparam logic [BLANK_W-1:0] BLANK_CYC_3 = scpMinCycles(BLANK_NS_3);

    // protection counting: error limit in overcurrent events, lock and quiet times in PWM cycles
    localparam logic [1:0] ERR_LIMIT    = 2'h3;
    localparam logic [5:0] LOCK_CYCLES  = 6'h3F;
    localparam logic [6:0] QUIET_CYCLES = 7'h3F;

    // telegram and coil word layout
    localparam int         TELEGRAM_BITS = 12;
    localparam int         COIL_BITS     = 6;
    localparam int         SIGN_BIT      = 0;
    localparam int         MAG_LSB       = 1;
    localparam int         MAG_MSB       = 4;
    localparam int         DECAY_BIT     = 5;
    localparam logic [3:0] MAG_ZERO      = 4'h0;
    localparam logic [3:0] MAG_FULL      = 4'hF;
    localparam logic [3:0] MAG_OFFSET    = 4'h1;
    localparam logic [3:0] RX_FULL       = 4'hC;
    localparam logic [3:0] RX_OVER       = 4'hD;

    // host wave stepping
    localparam logic [5:0]  PHASE_AHEAD       = 6'h10;
    localparam logic [11:0] DECAY_INVERT_MASK = 12'h820;
    localparam logic [5:0] SINE_TAB [64] = '{
        6'h00, 6'h02, 6'h06, 6'h08, 6'h0C, 6'h0E, 6'h10, 6'h14,
        6'h16, 6'h18, 6'h18, 6'h1A, 6'h1C, 6'h1C, 6'h1E, 6'h1E,
        6'h3E, 6'h3E, 6'h3E, 6'h3C, 6'h3C, 6'h3A, 6'h38, 6'h38,
        6'h36, 6'h34, 6'h30, 6'h2E, 6'h2C, 6'h28, 6'h26, 6'h22,
        6'h01, 6'h03, 6'h07, 6'h09, 6'h0D, 6'h0F, 6'h11, 6'h15,
        6'h17, 6'h19, 6'h19, 6'h1B, 6'h1D, 6'h1D, 6'h1F, 6'h1F,
        6'h3F, 6'h3F, 6'h3F, 6'h3D, 6'h3D, 6'h3B, 6'h39, 6'h39,
        6'h37, 6'h35, 6'h31, 6'h2F, 6'h2D, 6'h29, 6'h27, 6'h23};

    // host register map, byte addresses
    localparam logic [7:0] REG_STEP   = 8'h00;
    localparam logic [7:0] REG_RAW    = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_CONFIG = 8'h0C;
    localparam logic [7:0] REG_LAST   = 8'h10;

    // half period of the serial clock in core cycles
    localparam int SCLK_HALF_DEF = 4;
endpackage

// file: shared/scp_link_if.sv
// serial telegram link between host controller and device
`timescale 1ns/1ps
`default_nettype none
interface scp_link_if;
    logic sclk;
    logic csN;
    logic mosi;
    modport host (output sclk, output csN, output mosi);
    modport dev  (input sclk, input csN, input mosi);
endinterface
`default_nettype wire

// file: src/scp_host.sv
// host controller: AHB-Lite registers, wave stepping and serial telegram sender
`timescale 1ns/1ps
`default_nettype none
module scp_host
    import scp_pkg::*;
#(
    parameter int SCLK_HALF = SCLK_HALF_DEF
)(
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic      [31:0] hrdata,
    output logic             hresp,
    scp_link_if.host         link
);
    typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_END, ST_GAP} scp_tx_state_t;

    function automatic logic [5:0] scpOffset(input logic [5:0] w, input logic en);
        logic [5:0] r;
        r = w;
        if (en && w[MAG_MSB:MAG_LSB] != MAG_ZERO && w[MAG_MSB:MAG_LSB] != MAG_FULL) begin
            r[MAG_MSB:MAG_LSB] = w[MAG_MSB:MAG_LSB] + MAG_OFFSET;
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // bus slave
    logic        wrPend_r;
    logic [7:0]  wrAddr_r;
    logic [31:0] hrdata_r;
    logic        offsetEn_r;
    logic [5:0]  index_r;
    logic [11:0] lastTel_r;
    scp_tx_state_t state_r;

    wire        addrPhase = hsel && htrans[1] && hready;
    wire [7:0]  aOff      = haddr[7:0];
    wire        busy      = state_r != ST_IDLE;
    wire [31:0] rdMux     = (aOff == REG_STATUS) ? {23'h0, busy, 2'h0, index_r} :
                            (aOff == REG_CONFIG) ? {31'h0, offsetEn_r} :
                            (aOff == REG_LAST)   ? {20'h0, lastTel_r} : 32'h0;
    wire        wrStep    = wrPend_r && wrAddr_r == REG_STEP && !busy;
    wire        wrRaw     = wrPend_r && wrAddr_r == REG_RAW && !busy;
    wire        reverse   = hwdata[0];
    wire [5:0]  nextIdx   = reverse ? index_r - 6'h01 : index_r + 6'h01;
    wire [5:0]  wordA     = scpOffset(SINE_TAB[nextIdx], offsetEn_r);
    wire [5:0]  wordB     = scpOffset(SINE_TAB[nextIdx + PHASE_AHEAD], offsetEn_r);
    // the table already carries the decay bit on falling magnitude
    wire [11:0] stepTel   = {wordA, wordB} ^ (reverse ? DECAY_INVERT_MASK : 12'h000);

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            wrPend_r   <= 1'b0;
            wrAddr_r   <= 8'h00;
            hrdata_r   <= 32'h0;
            offsetEn_r <= 1'b0;
            index_r    <= 6'h00;
        end else begin
            wrPend_r <= addrPhase && hwrite;
            wrAddr_r <= aOff;
            if (addrPhase && !hwrite) begin
                hrdata_r <= rdMux;
            end
            if (wrPend_r && wrAddr_r == REG_CONFIG) begin
                offsetEn_r <= hwdata[0];
            end
            if (wrStep) begin
                index_r <= nextIdx;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // serial sender, mode 0: data set while the clock is low, sampled on its rise
    localparam int HW = $clog2(SCLK_HALF + 1);
    logic [HW-1:0] half_r;
    logic [11:0]   shift_r;
    logic [3:0]    bitCnt_r;
    logic          sclk_r;
    logic          csN_r;
    logic          mosi_r;

    wire halfDone = half_r == HW'(SCLK_HALF - 1);
    wire [11:0] newTel = wrStep ? stepTel : hwdata[11:0];

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_r   <= ST_IDLE;
            half_r    <= '0;
            shift_r   <= 12'h000;
            bitCnt_r  <= 4'h0;
            sclk_r    <= 1'b0;
            csN_r     <= 1'b1;
            mosi_r    <= 1'b0;
            lastTel_r <= 12'h000;
        end else begin
            half_r <= (state_r == ST_IDLE || halfDone) ? '0 : half_r + 1'b1;
            case (state_r)
                ST_IDLE: begin
                    if (wrStep || wrRaw) begin
                        csN_r     <= 1'b0;
                        shift_r   <= newTel;
                        mosi_r    <= newTel[11];
                        lastTel_r <= newTel;
                        bitCnt_r  <= 4'h0;
                        state_r   <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    if (halfDone) begin
                        sclk_r <= ~sclk_r;
                        if (!sclk_r) begin
                            bitCnt_r <= bitCnt_r + 4'h1;
                        end else if (bitCnt_r == RX_FULL) begin
                            state_r <= ST_END;
                        end else begin
                            shift_r <= {shift_r[10:0], 1'b0};
                            mosi_r  <= shift_r[10];
                        end
                    end
                end
                ST_END: begin
                    if (halfDone) begin
                        csN_r   <= 1'b1;
                        state_r <= ST_GAP;
                    end
                end
                default: begin
                    if (halfDone) begin
                        state_r <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign link.sclk = sclk_r;
    assign link.csN  = csN_r;
    assign link.mosi = mosi_r;
    assign hreadyout = 1'b1;
    assign hrdata    = hrdata_r;
    assign hresp     = 1'b0;
endmodule
`default_nettype wire

// file: verification/scp_properties.sv
// serial telegram link checker: framing, clock levels and bit count on the wire
`timescale 1ns/1ps
`default_nettype none
module scp_properties #(
    parameter int SCLK_HALF = 4
)(
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic sclk,
    input  wire logic csN,
    input  wire logic mosi
);
    // csN low for 12 serial periods plus the closing half period
    localparam int FRAME_CYC = 25 * SCLK_HALF;
    logic [3:0] bitCnt_r;

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    always_ff @(posedge core_clk) begin
        if (!rst_n || csN) begin
            bitCnt_r <= 4'h0;
        end else if ($rose(sclk)) begin
            bitCnt_r <= bitCnt_r + 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    sequence frameStart;
        $fell(csN);
    endsequence
    // written for the default half period of four cycles
    sequence firstHalf;
        (!sclk)[*4] ##1 sclk;
    endsequence

    a_idle_clock_low: assert property (csN |-> !sclk)
        else $error("serial clock high outside a frame");
    a_first_half: assert property (frameStart |-> firstHalf)
        else $error("first serial clock rise not one half period after select");
    a_high_min: assert property ($rose(sclk) |-> sclk[*3])
        else $error("serial clock high level too short");
    a_low_min: assert property ($fell(sclk) && !csN |-> (!sclk)[*3])
        else $error("serial clock low level too short");
    a_mosi_steady: assert property (!csN && sclk |-> $stable(mosi))
        else $error("data changed while serial clock high");
    a_frame_length: assert property (frameStart |-> ##FRAME_CYC $rose(csN))
        else $error("select not released at the end of the frame");
    a_twelve_bits: assert property ($rose(csN) |-> bitCnt_r == 4'hC)
        else $error("frame did not carry twelve bits");
    a_gap_min: assert property ($rose(csN) |-> csN[*4])
        else $error("select high too short between frames");
endmodule
`default_nettype wire

// file: verification/stepper_chopper_protection_test.sv
// bench: host controller driving the device across the serial link
`timescale 1ns/1ps
`default_nettype none
module stepper_chopper_protection_test
    import scp_pkg::*;
;
    typedef struct packed {logic [11:0] raw; logic [7:0] mag; logic [1:0] sgn; logic [1:0] dec;} scp_row_t;
    localparam scp_row_t ROWS [4] = '{{12'hFFF, 8'hFF, 2'h3, 2'h3}, {12'h81E, 8'hF0, 2'h0, 2'h1},
                                      {12'h043, 8'h10, 2'h3, 2'h0}, {12'h5A5, 8'h2B, 2'h2, 2'h2}};
    logic        core_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        pwmOsc = 1'b0;
    logic        chipDisableInput = 1'b0;
    logic        overTemp = 1'b0;
    logic        hsComp = 1'b0;
    logic [1:0]  lsComp = 2'h0;
    logic [1:0]  chopComp = 2'h0;
    // straps held at the usual 1.2 us blank setting
    logic        blankSelectHi = 1'b1;
    logic        blankSelectLo = 1'b0;
    logic        hresp;
    logic [1:0]  bridgeOn, coilSign, coilDecay;
    logic [7:0]  coilMag;
    logic [2:0]  errFlag;
    logic        overTempFlag;
    logic [31:0] rd;
    logic [11:0] tel;
    int          pwmCnt = 0;
    int          bad_count = 0;
    int          checks = 0;

    scp_link_if link ();
    scp_device scp_device_inst (.core_clk(core_clk), .rst_n(rst_n), .link(link.dev), .pwmOsc(pwmOsc),
        .chipDisableInput(chipDisableInput), .blankSelectHi(blankSelectHi), .blankSelectLo(blankSelectLo),
        .chopComp(chopComp), .lsComp(lsComp), .hsComp(hsComp), .overTemp(overTemp), .bridgeOn(bridgeOn),
        .coilSign(coilSign),
        .coilMag(coilMag), .coilDecay(coilDecay), .errFlag(errFlag), .overTempFlag(overTempFlag));
    scp_host #(.SCLK_HALF(4)) scp_host_inst (.core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .link(link.host));
    scp_properties #(.SCLK_HALF(4)) scp_properties_inst (.core_clk(core_clk), .rst_n(rst_n), .sclk(link.sclk),
        .csN(link.csN), .mosi(link.mosi));

    always #4 core_clk = ~core_clk;
    // slow chopper oscillator: 300 core cycles per level
    always @(posedge core_clk) begin
        pwmCnt <= (pwmCnt == 299) ? 0 : pwmCnt + 1;
        if (pwmCnt == 299) pwmOsc <= ~pwmOsc;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, a};
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic poll;
        rd = 32'h100;
        while (rd[8] !== 1'b0) bus(1'b0, REG_STATUS, 32'h0);
    endtask
    // a frame is latched a few cycles after select rises, so allow a short settle
    task automatic send(input logic [7:0] a, input logic [31:0] d);
        poll();
        bus(1'b1, a, d);
        poll();
        repeat (8) @(posedge core_clk);
    endtask
    task automatic stepChk(input logic rev, input logic [5:0] idx);
        send(REG_STEP, {31'h0, rev});
        tel = {SINE_TAB[idx], SINE_TAB[idx + 6'h10]} ^ (rev ? DECAY_INVERT_MASK : 12'h0);
        bus(1'b0, REG_LAST, 32'h0);
        chk(rd, {20'h0, tel});
        bus(1'b0, REG_STATUS, 32'h0);
        chk(32'(rd[5:0]), 32'(idx));
        chk(32'(coilMag), {24'h0, tel[4:1], tel[10:7]});
        chk(32'({coilSign, coilDecay}), {28'h0, tel[0], tel[6], tel[5], tel[11]});
    endtask
    task automatic pulse(input logic [2:0] src, input int dly);
        @(posedge pwmOsc);
        repeat (dly) @(posedge core_clk);
        lsComp <= src[1:0];
        hsComp <= src[2];
        repeat (20) @(posedge core_clk);
        lsComp <= 2'h0;
        hsComp <= 1'b0;
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            send(REG_RAW, {20'h0, ROWS[i].raw});
            chk(32'(coilMag), 32'(ROWS[i].mag));
            chk(32'({coilSign, coilDecay}), 32'({ROWS[i].sgn, ROWS[i].dec}));
        end
        bus(1'b1, 8'h40, 32'hFFF);
        bus(1'b0, 8'h40, 32'h0);
        chk(rd, 32'h0);
        bus(1'b1, REG_CONFIG, 32'h1);
        bus(1'b0, REG_CONFIG, 32'h0);
        chk(rd, 32'h1);
        chk(32'(hresp), 32'h0);
        bus(1'b1, REG_CONFIG, 32'h0);
        stepChk(1'b1, 6'h3F);
        stepChk(1'b0, 6'h00);
        // offset on: entry 1 magnitude 1 becomes 2, the full-scale word is left alone
        bus(1'b1, REG_CONFIG, 32'h1);
        send(REG_STEP, 32'h0);
        bus(1'b0, REG_LAST, 32'h0);
        chk(rd, 32'h13E);
        bus(1'b1, REG_CONFIG, 32'h0);
        send(REG_RAW, 32'hFFF);
        // first pulse falls inside the blank and must not count
        pulse(3'h1, 20);
        pulse(3'h1, 200);
        chk(32'(bridgeOn[0]), 32'h0);
        pulse(3'h1, 200);
        chk(32'(errFlag), 32'h0);
        pulse(3'h1, 200);
        chk(32'(errFlag), 32'h1);
        pulse(3'h0, 200);
        chk(32'(bridgeOn[0]), 32'h0);
        send(REG_RAW, 32'h0);
        chk(32'(errFlag), 32'h0);
        send(REG_RAW, 32'hFFF);
        pulse(3'h0, 200);
        chk(32'(bridgeOn), 32'h3);
        pulse(3'h4, 200);
        chk(32'(bridgeOn), 32'h0);
        overTemp <= 1'b1;
        repeat (10) @(posedge core_clk);
        chk(32'({overTempFlag, bridgeOn}), 32'h4);
        overTemp <= 1'b0;
        pulse(3'h0, 200);
        chk(32'({overTempFlag, bridgeOn}), 32'h3);
        // target reached early in the cycle: the 1.2 us blank holds bridge A on, then it chops
        @(posedge pwmOsc);
        repeat (20) @(posedge core_clk);
        chopComp <= 2'h1;
        repeat (120) @(posedge core_clk);
        chk(32'(bridgeOn), 32'h3);
        repeat (40) @(posedge core_clk);
        chk(32'({errFlag, bridgeOn}), 32'h2);
        chopComp <= 2'h0;
        // coil B at zero magnitude, so only bridge A can meet the high-side fault
        send(REG_RAW, 32'hFC0);
        pulse(3'h0, 200);
        chk(32'(bridgeOn), 32'h1);
        pulse(3'h4, 200);
        chk(32'(bridgeOn), 32'h0);
        chipDisableInput <= 1'b1;
        repeat (10) @(posedge core_clk);
        chk(32'({coilMag, bridgeOn, errFlag}), 32'h0);
        chipDisableInput <= 1'b0;
        send(REG_RAW, 32'hFFF);
        rst_n <= 1'b0;
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        chk(32'({coilMag, bridgeOn, errFlag}), 32'h0);
        bus(1'b0, REG_STATUS, 32'h0);
        chk(rd, 32'h0);
        wrap_up();
    end
    initial begin
        repeat (60000) @(posedge core_clk);
        bad_count++;
        wrap_up();
    end
endmodule
`default_nettype wire
